//--- tjm_pkg.sv
// Summary of operation
// - Host reads output slot: release, low, sample, high.
// - Host skips read: release, low, high, redrive.
// - Idle input slot level drives target CPU clock.
// - Host holds mode-select low while clocking CPU.
// - Falling-only edge: line rises during mode-select low.
// - Optional burst of CPU clocks within one slot.
// - Eight-bit instructions shifted in LSB first.
// - Decode 0x83 address load, 0x84 address capture.
// - Decode 0x85, 0x41, 0x43 data accesses.
// - Decode 0x44 signature feed, 0x46 readout.
// - Decode 0x22 fuse prepare, 0x24 fuse burn.
// - Decode 0xff, 0x13, 0x14; host avoids unlisted codes.
// - Update-IR applies instruction; capture/update data registers.
// - CPU clock edges accepted only in Run-Test/Idle.
// - Address load shift drives address bus, shifts old.
// - Sixteen-bit address shift keeps bits 19:16.
// - Address capture shifts bus out, ignores input.
// - Write-at-address drives data bus from held address.
// - Data-at-counter sets data bus, CPU owns address.
// - Slots cycle mode-select, data-in, data-out.
// - Mode and data sampled on link clock fall.
// - Device drives output slot only while clock low.
// - Overlong clock low phase deactivates the link.
package tjm_pkg;
	localparam int SYS_MHZ = 40;
	localparam int HOST_NOP = 5;
	localparam int HOST_NOP_MHZ = 18;
	localparam int HOST_WAIT_CYC = (HOST_NOP * SYS_MHZ + HOST_NOP_MHZ - 1) / HOST_NOP_MHZ;
	localparam int LOW_MAX_US = 7;
	localparam int LOW_MAX_CYC = LOW_MAX_US * SYS_MHZ;
	localparam int IR_W = 8;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 20;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] WIDE_SHIFT = 5'h14;
	localparam logic [4:0] ADDR_MSB = 5'h13;
	localparam logic [4:0] DATA_MSB = 5'h0f;
	localparam logic [7:0] IR_ADDR_LOAD = 8'h83;
	localparam logic [7:0] IR_ADDR_CAP = 8'h84;
	localparam logic [7:0] IR_DATA_ADDR = 8'h85;
	localparam logic [7:0] IR_DATA_PC = 8'h41;
	localparam logic [7:0] AUTO_INCREMENT_DATA_INSTR = 8'h43;
	localparam logic [7:0] IR_SIG_FEED = 8'h44;
	localparam logic [7:0] IR_SIG_OUT = 8'h46;
	localparam logic [7:0] IR_FUSE_PREP = 8'h22;
	localparam logic [7:0] IR_FUSE_BURN = 8'h24;
	localparam logic [7:0] PASS_THROUGH_INSTR = 8'hff;
	localparam logic [7:0] IR_CTRL_WR = 8'h13;
	localparam logic [7:0] IR_CTRL_CAP = 8'h14;
	localparam logic [7:0] IR_CAPTURE_PAT = 8'h01;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	typedef enum logic [3:0] {
		K_OTHER, K_ADDR_LOAD, K_ADDR_CAP, K_DATA_ADDR, K_DATA_PC, K_DATA_QUICK,
		K_SIG_FEED, K_SIG_OUT, K_FUSE_PREP, K_FUSE_BURN, K_BYPASS, K_CTRL_WR, K_CTRL_CAP
	} tjm_kind_e;

	typedef enum logic [2:0] {
		SLOT_MODE = 3'b001,
		SLOT_IN = 3'b010,
		SLOT_OUT = 3'b100
	} tjm_slot_e;

	typedef enum logic [15:0] {
		TAP_RESET = 16'h0001,
		TAP_IDLE = 16'h0002,
		TAP_SEL_DR = 16'h0004,
		TAP_CAP_DR = 16'h0008,
		TAP_SH_DR = 16'h0010,
		TAP_EX1_DR = 16'h0020,
		TAP_PAU_DR = 16'h0040,
		TAP_EX2_DR = 16'h0080,
		TAP_UPD_DR = 16'h0100,
		TAP_SEL_IR = 16'h0200,
		TAP_CAP_IR = 16'h0400,
		TAP_SH_IR = 16'h0800,
		TAP_EX1_IR = 16'h1000,
		TAP_PAU_IR = 16'h2000,
		TAP_EX2_IR = 16'h4000,
		TAP_UPD_IR = 16'h8000
	} tjm_tap_e;

	// Instruction decode shared by capture, update and bus ownership
	function automatic tjm_kind_e tjm_decode(input logic [7:0] ir);
		case (ir)
			IR_ADDR_LOAD: tjm_decode = K_ADDR_LOAD;
			IR_ADDR_CAP: tjm_decode = K_ADDR_CAP;
			IR_DATA_ADDR: tjm_decode = K_DATA_ADDR;
			IR_DATA_PC: tjm_decode = K_DATA_PC;
			AUTO_INCREMENT_DATA_INSTR: tjm_decode = K_DATA_QUICK;
			IR_SIG_FEED: tjm_decode = K_SIG_FEED;
			IR_SIG_OUT: tjm_decode = K_SIG_OUT;
			IR_FUSE_PREP: tjm_decode = K_FUSE_PREP;
			IR_FUSE_BURN: tjm_decode = K_FUSE_BURN;
			PASS_THROUGH_INSTR: tjm_decode = K_BYPASS;
			IR_CTRL_WR: tjm_decode = K_CTRL_WR;
			IR_CTRL_CAP: tjm_decode = K_CTRL_CAP;
			default: tjm_decode = K_OTHER;
		endcase
	endfunction : tjm_decode
endpackage : tjm_pkg

//--- tjm_link_if.sv
`timescale 1ns/1ps
interface tjm_link_if;
	logic clk_line;
	logic host_dat;
	logic host_oe;
	logic dev_dat;
	logic dev_oe;
	logic line;

	// Undriven line reads high, standing in for the bus keeper
	assign line = host_oe ? host_dat : (dev_oe ? dev_dat : 1'b1);

	modport host(output clk_line, output host_dat, output host_oe, input line);
	modport dev(input clk_line, input line, output dev_dat, output dev_oe);
endinterface : tjm_link_if

//--- tjm_sync_edge.sv
`timescale 1ns/1ps
module tjm_sync_edge #(
	parameter bit RST_VAL = 1'b1
) (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_async,
	output logic o_level,
	output logic o_rise,
	output logic o_fall
);
	logic meta;
	logic prev;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			meta <= RST_VAL;
			o_level <= RST_VAL;
			prev <= RST_VAL;
		end else begin
			meta <= i_async;
			o_level <= meta;
			prev <= o_level;
		end
	end

	assign o_rise = o_level & ~prev;
	assign o_fall = ~o_level & prev;
endmodule : tjm_sync_edge

//--- tjm_device.sv
`timescale 1ns/1ps
module tjm_device #(
	parameter bit BURST_EN = 1'b1
) (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	tjm_link_if.dev link,
	input wire logic [19:0] i_mab,
	input wire logic [15:0] i_mdb,
	output logic o_link_active,
	output logic o_target_cpu_clock,
	output tjm_pkg::tjm_tap_e o_tap,
	output logic [7:0] o_instr,
	output tjm_pkg::tjm_kind_e o_kind,
	output logic [19:0] o_mab,
	output logic o_mab_drive,
	output logic [15:0] o_mdb,
	output logic o_mdb_drive,
	output logic o_mdb_wr,
	output logic [15:0] o_ctrl
);
	import tjm_pkg::*;

	//--------------------------------------------------------------
	// Link pin sampling
	//--------------------------------------------------------------
	logic clk_lvl, clk_rise, clk_fall, dat_lvl;

	tjm_sync_edge #(.RST_VAL(1'b1)) u_clk_sync (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
		.i_async(link.clk_line), .o_level(clk_lvl), .o_rise(clk_rise), .o_fall(clk_fall));

	tjm_sync_edge #(.RST_VAL(1'b1)) u_dat_sync (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
		.i_async(link.line), .o_level(dat_lvl), .o_rise(), .o_fall());

	//--------------------------------------------------------------
	// Activity watchdog and slot sequencing
	//--------------------------------------------------------------
	logic [8:0] low_cnt;
	logic active, tms, tdo_bit, drive;
	tjm_slot_e slot;

	wire low_timeout = (low_cnt == 9'(LOW_MAX_CYC));
	wire step = active & clk_fall & (slot == SLOT_IN);
	wire tdi = dat_lvl;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst || clk_lvl) begin
			low_cnt <= 9'h000;
		end else if (!low_timeout) begin
			low_cnt <= low_cnt + 9'h001;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst || low_timeout) begin
			active <= 1'b0;
		end else if (clk_fall) begin
			active <= 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst || !active) begin
			slot <= SLOT_MODE;
		end else if (clk_rise) begin
			case (slot)
				SLOT_MODE: slot <= SLOT_IN;
				SLOT_IN: slot <= SLOT_OUT;
				SLOT_OUT: slot <= SLOT_MODE;
				default: slot <= SLOT_MODE;
			endcase
		end
	end

	// Mode-select reads high while inactive; the waking fall is a mode-select sample
	always_ff @(posedge i_clk_sys) begin
		if (i_srst || (!active && !clk_fall)) begin
			tms <= 1'b1;
		end else if (clk_fall && slot == SLOT_MODE) begin
			tms <= dat_lvl;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst || !active || clk_rise) begin
			drive <= 1'b0;
		end else if (clk_fall && slot == SLOT_OUT) begin
			drive <= 1'b1;
		end
	end

	assign link.dev_oe = drive;
	assign link.dev_dat = tdo_bit;

	//--------------------------------------------------------------
	// TAP controller
	//--------------------------------------------------------------
	tjm_tap_e tap, next_tap;

	always_comb begin
		case (tap)
			TAP_RESET: next_tap = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: next_tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: next_tap = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: next_tap = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: next_tap = tms ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: next_tap = tms ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: next_tap = tms ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: next_tap = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: next_tap = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: next_tap = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: next_tap = tms ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: next_tap = tms ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: next_tap = tms ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
			default: next_tap = TAP_RESET;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst || !active) begin
			tap <= TAP_RESET;
		end else if (step) begin
			tap <= next_tap;
		end
	end

	//--------------------------------------------------------------
	// Instruction register
	//--------------------------------------------------------------
	logic [IR_W-1:0] ir_sh, ir;
	tjm_kind_e kind;

	assign kind = tjm_decode(ir);

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			ir_sh <= IR_CAPTURE_PAT;
			ir <= PASS_THROUGH_INSTR;
		end else if (tap == TAP_RESET) begin
			ir <= PASS_THROUGH_INSTR;
		end else if (step) begin
			if (tap == TAP_CAP_IR) begin
				ir_sh <= IR_CAPTURE_PAT;
			end
			if (tap == TAP_SH_IR) begin
				ir_sh <= {tdi, ir_sh[IR_W-1:1]};
			end
			if (tap == TAP_UPD_IR) begin
				ir <= ir_sh;
			end
		end
	end

	//--------------------------------------------------------------
	// Data register chain
	//--------------------------------------------------------------
	logic [ADDR_W-1:0] chain, addr;
	logic [CNT_W-1:0] shift_cnt;
	logic [DATA_W-1:0] ctrl;

	wire is_addr = (kind == K_ADDR_LOAD) || (kind == K_ADDR_CAP);
	wire is_data = (kind == K_DATA_ADDR) || (kind == K_DATA_PC) ||
		(kind == K_DATA_QUICK) || (kind == K_SIG_FEED);
	wire is_ctrl = (kind == K_CTRL_WR) || (kind == K_CTRL_CAP);
	wire [ADDR_W-1:0] addr_src = (kind == K_ADDR_CAP) ? i_mab : addr;
	// Low word leaves first so a 16-bit shift reads bit 15 first
	wire [ADDR_W-1:0] cap_val = is_addr ? {addr_src[15:0], addr_src[19:16]} :
		(is_data || is_ctrl || kind == K_SIG_OUT) ?
		{4'h0, (is_ctrl ? ctrl : i_mdb)} : {ADDR_W{1'b0}};
	wire [4:0] out_idx = is_addr ? ADDR_MSB :
		(kind == K_BYPASS || kind == K_OTHER) ? 5'h00 : DATA_MSB;
	wire wide = (shift_cnt >= WIDE_SHIFT);
	wire [ADDR_W-1:0] next_addr = wide ? {chain[3:0], chain[19:4]} :
		{addr[19:16], chain[15:0]};

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			chain <= {ADDR_W{1'b0}};
			shift_cnt <= {CNT_W{1'b0}};
		end else if (step && tap == TAP_CAP_DR) begin
			chain <= cap_val;
			shift_cnt <= {CNT_W{1'b0}};
		end else if (step && tap == TAP_SH_DR) begin
			chain <= {chain[ADDR_W-2:0], tdi};
			if (!wide) begin
				shift_cnt <= shift_cnt + 5'h01;
			end
		end
	end

	// Bit presented in the output slot following the shift step
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			tdo_bit <= 1'b0;
		end else if (step) begin
			tdo_bit <= (tap == TAP_SH_IR) ? ir_sh[0] :
				(tap == TAP_SH_DR) ? chain[out_idx] : 1'b0;
		end
	end

	//--------------------------------------------------------------
	// Update actions onto the CPU buses
	//--------------------------------------------------------------
	wire upd_dr = step && (tap == TAP_UPD_DR);

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			addr <= {ADDR_W{1'b0}};
			ctrl <= CTRL_RESET;
			o_mdb <= 16'h0000;
			o_mdb_drive <= 1'b0;
			o_mdb_wr <= 1'b0;
		end else begin
			o_mdb_wr <= 1'b0;
			if (upd_dr && kind == K_ADDR_LOAD) begin
				addr <= next_addr;
			end
			if (upd_dr && kind == K_CTRL_WR) begin
				ctrl <= chain[15:0];
			end
			if (upd_dr && (kind == K_DATA_ADDR || kind == K_DATA_PC ||
				kind == K_DATA_QUICK)) begin
				o_mdb <= chain[15:0];
				o_mdb_drive <= 1'b1;
				o_mdb_wr <= 1'b1;
			end
			if (step && tap == TAP_UPD_IR) begin
				o_mdb_drive <= 1'b0;
			end
		end
	end

	// Address bus owned by the held address only for address load, address capture and write-at-address
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_mab_drive <= 1'b0;
		end else begin
			o_mab_drive <= (kind == K_ADDR_LOAD) || (kind == K_ADDR_CAP) ||
				(kind == K_DATA_ADDR);
		end
	end

	//--------------------------------------------------------------
	// Target CPU clock from the input slot
	//--------------------------------------------------------------
	// The rise ending the slot already shows the released line, so it is ignored
	wire target_cpu_clock_gate = active && (tap == TAP_IDLE) && (slot == SLOT_IN) && !clk_rise;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_target_cpu_clock <= 1'b0;
		end else if (target_cpu_clock_gate && (BURST_EN || clk_fall)) begin
			o_target_cpu_clock <= dat_lvl;
		end
	end

	assign o_link_active = active;
	assign o_tap = tap;
	assign o_instr = ir;
	assign o_kind = kind;
	assign o_mab = addr;
	assign o_ctrl = ctrl;
endmodule : tjm_device

//--- tjm_host.sv
`timescale 1ns/1ps
module tjm_host (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	tjm_link_if.host link,
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire logic i_req_tms,
	input wire logic i_req_tdi,
	input wire logic i_req_read,
	input wire logic i_req_early_high,
	output logic o_rsp_valid,
	output logic o_rsp_tdo
);
	import tjm_pkg::*;

	typedef enum logic [7:0] {
		H_IDLE = 8'h01,
		H_MS_SET = 8'h02,
		H_MS_LOW = 8'h04,
		H_IN_SET = 8'h08,
		H_IN_LOW = 8'h10,
		H_OUT_SET = 8'h20,
		H_OUT_LOW = 8'h40,
		H_OUT_HOLD = 8'h80
	} tjm_hstate_e;

	//--------------------------------------------------------------
	// Returned line sampling
	//--------------------------------------------------------------
	logic line_lvl;

	tjm_sync_edge #(.RST_VAL(1'b1)) u_line_sync (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_async(link.line),
		.o_level(line_lvl),
		.o_rise(),
		.o_fall()
	);

	//--------------------------------------------------------------
	// Slot sequencer
	//--------------------------------------------------------------
	tjm_hstate_e state;
	logic [4:0] wcnt;
	logic clk_q;
	logic dat_q;
	logic oe_q;
	logic tdi_q;
	logic read_q;
	logic early_q;

	wire done = (wcnt == 5'(HOST_WAIT_CYC - 1));
	wire take = (state == H_IDLE) && i_req_valid;

	assign o_req_ready = (state == H_IDLE);

	always_ff @(posedge i_clk_sys) begin
		if (i_srst || state == H_IDLE || done) begin
			wcnt <= 5'h00;
		end else begin
			wcnt <= wcnt + 5'h01;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			state <= H_IDLE;
			clk_q <= 1'b1;
			dat_q <= 1'b1;
			oe_q <= 1'b1;
			tdi_q <= 1'b1;
			read_q <= 1'b0;
			early_q <= 1'b0;
			o_rsp_valid <= 1'b0;
			o_rsp_tdo <= 1'b0;
		end else begin
			o_rsp_valid <= 1'b0;
			case (state)
				H_IDLE: if (take) begin
					dat_q <= i_req_tms;
					tdi_q <= i_req_tdi;
					read_q <= i_req_read;
					early_q <= i_req_early_high;
					state <= H_MS_SET;
				end
				H_MS_SET: if (done) begin
					clk_q <= 1'b0;
					state <= H_MS_LOW;
				end
				H_MS_LOW: if (done) begin
					if (early_q) begin
						dat_q <= 1'b1;
					end
					state <= H_IN_SET;
				end
				H_IN_SET: begin
					clk_q <= 1'b1;
					if (wcnt == 5'h00) begin
						dat_q <= tdi_q;
					end
					if (done) begin
						clk_q <= 1'b0;
						state <= H_IN_LOW;
					end
				end
				H_IN_LOW: if (done) begin
					clk_q <= 1'b1;
					oe_q <= 1'b0;
					state <= H_OUT_SET;
				end
				H_OUT_SET: if (done) begin
					clk_q <= 1'b0;
					state <= H_OUT_LOW;
				end
				H_OUT_LOW: if (done) begin
					if (read_q) begin
						o_rsp_tdo <= line_lvl;
						state <= H_OUT_HOLD;
					end else begin
						clk_q <= 1'b1;
						oe_q <= 1'b1;
						o_rsp_valid <= 1'b1;
						state <= H_IDLE;
					end
				end
				H_OUT_HOLD: if (done) begin
					clk_q <= 1'b1;
					oe_q <= 1'b1;
					o_rsp_valid <= 1'b1;
					state <= H_IDLE;
				end
				default: state <= H_IDLE;
			endcase
		end
	end

	assign link.clk_line = clk_q;
	assign link.host_dat = dat_q;
	assign link.host_oe = oe_q;
endmodule : tjm_host

//--- tjm_chk.sv
`timescale 1ns/1ps
module tjm_chk (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic clk_line,
	input wire logic host_dat,
	input wire logic host_oe,
	input wire logic dev_dat,
	input wire logic dev_oe,
	input wire logic line
);
	// ----------------------------------------
	// Wire-level timing of the shared link
	// ----------------------------------------
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_srst);

	a_release_clock_high: assert property ($fell(host_oe) |-> clk_line)
		else $error("host released the line while the link clock was low");
	a_redrive_clock_high: assert property ($rose(host_oe) |-> clk_line)
		else $error("host drove the line again while the link clock was low");
	a_low_phase_min: assert property ($fell(clk_line) |-> !clk_line [*8])
		else $error("link clock low phase shorter than the wait");
	a_low_phase_bound: assert property ($fell(clk_line) |-> ##[8:40] clk_line)
		else $error("link clock low phase too long");
	a_host_data_steady: assert property ($fell(clk_line) && host_oe |-> $stable(host_dat))
		else $error("host data moved at the link clock fall");
	a_dev_answers_slot: assert property ($fell(clk_line) && !host_oe |-> ##[1:4] dev_oe)
		else $error("device did not drive the output slot");
	a_dev_starts_low: assert property ($rose(dev_oe) |-> !clk_line)
		else $error("device started driving with the link clock high");
	a_dev_waits_fall: assert property ($fell(host_oe) |-> !dev_oe [*8])
		else $error("device drove before the link clock fell");
	a_dev_drops_rise: assert property ($rose(clk_line) |-> ##[0:4] !dev_oe)
		else $error("device kept driving after the link clock rose");
	a_dev_value_held: assert property (dev_oe && $past(dev_oe) && !host_oe |-> $stable(line))
		else $error("device output bit changed within the low phase");
endmodule : tjm_chk

//--- two_wire_jtag_memory_access_bench.sv
`timescale 1ns/1ps
module two_wire_jtag_memory_access_bench;
	import tjm_pkg::*;
	logic clk_sys;
	logic srst;
	logic req_valid, req_tms, req_tdi, req_read, req_early;
	logic req_ready, rsp_valid, rsp_tdo, link_active, target_cpu_clock, mab_drive, mdb_drive, mdb_wr;
	logic lone_active;
	logic [19:0] mab_in, mab_out, got;
	logic [15:0] mdb_in, mdb_out, ctrl;
	logic [7:0] instr;
	logic b;
	tjm_tap_e tap;
	tjm_kind_e kind;
	int fails, tests_run, wr_pulses, w0;
	logic [7:0] codes [12] = '{8'h83, 8'h84, 8'h85, 8'h41, 8'h43, 8'h44, 8'h46, 8'h22, 8'h24,
		8'hff, 8'h13, 8'h14};
	tjm_kind_e kinds [12] = '{K_ADDR_LOAD, K_ADDR_CAP, K_DATA_ADDR, K_DATA_PC, K_DATA_QUICK,
		K_SIG_FEED, K_SIG_OUT, K_FUSE_PREP, K_FUSE_BURN, K_BYPASS, K_CTRL_WR, K_CTRL_CAP};

	tjm_link_if link();
	tjm_link_if link_lone();

	tjm_host i_tjm_host (.i_clk_sys(clk_sys), .i_srst(srst), .link(link.host),
		.i_req_valid(req_valid), .o_req_ready(req_ready), .i_req_tms(req_tms),
		.i_req_tdi(req_tdi), .i_req_read(req_read), .i_req_early_high(req_early),
		.o_rsp_valid(rsp_valid), .o_rsp_tdo(rsp_tdo));
	tjm_device i_tjm_device (.i_clk_sys(clk_sys), .i_srst(srst), .link(link.dev),
		.i_mab(mab_in), .i_mdb(mdb_in), .o_link_active(link_active), .o_target_cpu_clock(target_cpu_clock),
		.o_tap(tap), .o_instr(instr), .o_kind(kind), .o_mab(mab_out),
		.o_mab_drive(mab_drive), .o_mdb(mdb_out), .o_mdb_drive(mdb_drive),
		.o_mdb_wr(mdb_wr), .o_ctrl(ctrl));
	// Second device whose link the bench drives directly, overstaying the clock low phase
	tjm_device i_tjm_device_lone (.i_clk_sys(clk_sys), .i_srst(srst), .link(link_lone.dev),
		.i_mab(20'h00000), .i_mdb(16'h0000), .o_link_active(lone_active), .o_target_cpu_clock(),
		.o_tap(), .o_instr(), .o_kind(), .o_mab(), .o_mab_drive(), .o_mdb(),
		.o_mdb_drive(), .o_mdb_wr(), .o_ctrl());
	tjm_chk i_tjm_chk (.i_clk_sys(clk_sys), .i_srst(srst), .clk_line(link.clk_line),
		.host_dat(link.host_dat), .host_oe(link.host_oe), .dev_dat(link.dev_dat),
		.dev_oe(link.dev_oe), .line(link.line));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) if (mdb_wr === 1'b1) wr_pulses <= wr_pulses + 1;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input string name, input logic [19:0] exp, input logic [19:0] seen);
		tests_run++;
		if (seen !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
			fails++;
		end
	endtask : chk

	task summarize;
		if (fails == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize

	task step(input logic tms, input logic tdi, input logic rd, input logic early,
		output logic tdo);
		int n;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_tms <= tms;
		req_tdi <= tdi;
		req_read <= rd;
		req_early <= early;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (rsp_valid !== 1'b1 && n < 200);
		if (n >= 200) chk("rsp_valid", 20'h1, 20'h0);
		tdo = rsp_tdo;
	endtask : step

	// Mode-select steps without readback, first bit from the top
	task nav(input logic [3:0] seq, input int n);
		for (int i = n - 1; i >= 0; i--) step(seq[i], 1'b0, 1'b0, 1'b0, b);
	endtask : nav

	// Instruction bits go LSB first, data bits MSB first
	task shift(input logic ir, input int n, input logic [19:0] vin, output logic [19:0] vout);
		logic [7:0] old_ir;
		old_ir = instr;
		vout = '0;
		if (ir) nav(4'b1100, 4);
		else nav(4'b0100, 3);
		for (int k = 0; k < n; k++) begin
			int i;
			i = ir ? k : n - 1 - k;
			step(k == n - 1, vin[i], 1'b1, 1'b0, b);
			vout[i] = b;
		end
		if (ir) chk("instr_held", {12'h000, old_ir}, {12'h000, instr});
		nav(4'b0010, 2);
	endtask : shift

	initial begin
		repeat (80000) @(posedge clk_sys);
		fails++;
		summarize;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		srst = 1'b1;
		{req_valid, req_tms, req_tdi, req_read, req_early} = 5'h00;
		mab_in = 20'h5a3c7;
		mdb_in = 16'h1234;
		{link_lone.clk_line, link_lone.host_oe, link_lone.host_dat} = 3'h7;
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		@(negedge clk_sys);
		chk("instr_rst", 20'h000ff, {12'h000, instr});
		chk("tap_rst", {4'h0, TAP_RESET}, {4'h0, tap});
		chk("active_rst", 20'h0, {19'h0, link_active});
		chk("dev_oe_rst", 20'h0, {19'h0, link.dev_oe});
		chk("ready_rst", 20'h1, {19'h0, req_ready});
		nav(4'b0010, 2);
		chk("tap_idle", {4'h0, TAP_IDLE}, {4'h0, tap});
		for (int r = 0; r < 12; r++) begin
			shift(1'b1, 8, {12'h000, codes[r]}, got);
			chk("ir_capture", 20'h00001, got);
			chk("instr", {12'h000, codes[r]}, {12'h000, instr});
			chk("kind", {16'h0000, kinds[r]}, {16'h0000, kind});
		end
		shift(1'b1, 8, 20'h00083, got);
		chk("mab_drive", 20'h1, {19'h0, mab_drive});
		shift(1'b0, 20, 20'h25681, got);
		chk("mab_old", 20'h00000, got);
		chk("mab_wide", 20'h12568, mab_out);
		shift(1'b0, 16, 20'h09a5f, got);
		chk("mab_old16", 20'h02568, got);
		chk("mab_narrow", 20'h19a5f, mab_out);
		shift(1'b1, 8, 20'h00084, got);
		shift(1'b0, 20, 20'hfffff, got);
		chk("mab_capture", 20'ha3c75, got);
		chk("mab_kept", 20'h19a5f, mab_out);
		w0 = wr_pulses;
		shift(1'b1, 8, 20'h00085, got);
		shift(1'b0, 16, 20'h0beef, got);
		chk("mdb_prior", 20'h01234, got);
		chk("mdb_set", 20'h0beef, {4'h0, mdb_out});
		chk("mdb_drive", 20'h1, {19'h0, mdb_drive});
		chk("mab_drive_wr", 20'h1, {19'h0, mab_drive});
		chk("wr_pulses", 20'h1, 20'(wr_pulses - w0));
		chk("target_cpu_clock_shift", 20'h0, {19'h0, target_cpu_clock});
		shift(1'b1, 8, 20'h00041, got);
		chk("mdb_release", 20'h0, {19'h0, mdb_drive});
		shift(1'b0, 16, 20'h0c0de, got);
		chk("mdb_prior_pc", 20'h01234, got);
		chk("mdb_pc", 20'h0c0de, {4'h0, mdb_out});
		chk("mab_cpu", 20'h0, {19'h0, mab_drive});
		shift(1'b1, 8, 20'h00013, got);
		shift(1'b0, 16, 20'h05a5a, got);
		chk("ctrl_prior", {4'h0, CTRL_RESET}, got);
		chk("ctrl_set", 20'h05a5a, {4'h0, ctrl});
		shift(1'b0, 16, 20'h00000, got);
		chk("ctrl_last", 20'h05a5a, got);
		step(1'b0, 1'b1, 1'b0, 1'b0, b);
		chk("target_cpu_clock_rise", 20'h1, {19'h0, target_cpu_clock});
		chk("tap_stay", {4'h0, TAP_IDLE}, {4'h0, tap});
		step(1'b0, 1'b0, 1'b0, 1'b1, b);
		chk("target_cpu_clock_fall", 20'h0, {19'h0, target_cpu_clock});
		chk("tap_stay_fall", {4'h0, TAP_IDLE}, {4'h0, tap});
		@(posedge clk_sys);
		link_lone.clk_line <= 1'b0;
		repeat (20) @(posedge clk_sys);
		link_lone.clk_line <= 1'b1;
		repeat (10) @(posedge clk_sys);
		chk("lone_on", 20'h1, {19'h0, lone_active});
		link_lone.clk_line <= 1'b0;
		repeat (200) @(posedge clk_sys);
		chk("lone_short", 20'h1, {19'h0, lone_active});
		repeat (120) @(posedge clk_sys);
		chk("lone_off", 20'h0, {19'h0, lone_active});
		summarize;
	end
endmodule : two_wire_jtag_memory_access_bench
